// ===== rtl/tppc_top.sv
/*
 * Three-phase PWM pair generator (reset-synchronized and complementary)
 * with a quadrature phase counter, registers on APB.
 * Assumes ref_clk at 250 MHz, encoder inputs asynchronous to it.
 */
module tppc_top (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pwm pins
    output logic             phase1_out,
    output logic             phase1_out_n,
    output logic             phase2_out,
    output logic             phase2_out_n,
    output logic             phase3_out,
    output logic             phase3_out_n,
    output logic             pwmPinEn,
    // encoder inputs
    input  wire logic        quad_input_a,
    input  wire logic        quad_input_b
);
    logic [8:0]  ctrl_r;
    logic [4:0]  stat_r;
    logic [15:0] primary_pwm_counter;
    logic [15:0] secondary_pwm_counter;
    logic [15:0] pwm_period_register;
    logic [15:0] trans_r [3];
    logic [15:0] buf_r [3];
    logic [15:0] quadrature_counter;
    logic [15:0] quad_compare_a;
    logic [15:0] quad_compare_b;
    tppc_pkg::tppc_dir_t dir_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] rdMux;
    logic        rdHit;

    function automatic logic hitReg(input logic [7:0] a, input logic [7:0] off);
        hitReg = (a == off);
    endfunction

    // bus decode
    wire        wrEn   = psel & penable & pready_r & pwrite;
    wire        wrCtrl = wrEn & hitReg(paddr, tppc_pkg::OFF_CTRL);
    wire        wrStat = wrEn & hitReg(paddr, tppc_pkg::OFF_STAT);
    wire        wrPri  = wrEn & hitReg(paddr, tppc_pkg::OFF_PRICNT);
    wire        wrSec  = wrEn & hitReg(paddr, tppc_pkg::OFF_SECCNT);
    wire        wrPer  = wrEn & hitReg(paddr, tppc_pkg::OFF_PERIOD);
    wire        wrQcnt = wrEn & hitReg(paddr, tppc_pkg::OFF_QCNT);
    wire        wrQa   = wrEn & hitReg(paddr, tppc_pkg::OFF_QCMPA);
    wire        wrQb   = wrEn & hitReg(paddr, tppc_pkg::OFF_QCMPB);
    wire [1:0]  mode   = ctrl_r[tppc_pkg::CTRL_MODE +: 2];
    wire        run    = ctrl_r[tppc_pkg::CTRL_RUN];
    wire        rsync  = run & (mode == tppc_pkg::MODE_RSYNC);
    wire        comp   = run & (mode == tppc_pkg::MODE_COMP);
    wire        up     = (dir_r == tppc_pkg::TPPC_UP);
    wire        perHit = (primary_pwm_counter == pwm_period_register);
    wire        secZero = (secondary_pwm_counter == tppc_pkg::CNT_ZERO);
    wire        secMax  = (secondary_pwm_counter == tppc_pkg::CNT_MAX);
    wire        underflow = comp & ~up & secZero;
    wire        turnDown  = comp & up & perHit;
    wire        bufXfer = ctrl_r[tppc_pkg::CTRL_BUF]
                        & ((rsync & perHit) | turnDown | underflow);
    wire        cmpaSet = (rsync & perHit) | turnDown;
    wire        ovfSet  = (rsync & secMax) | underflow;

    // read select, registered at setup so data is stable in access
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        unique case (paddr)
            tppc_pkg::OFF_CTRL:   rdMux[8:0] = ctrl_r;
            tppc_pkg::OFF_STAT:   rdMux[5:0] = {dir_r == tppc_pkg::TPPC_DOWN, stat_r};
            tppc_pkg::OFF_PRICNT: rdMux[15:0] = primary_pwm_counter;
            tppc_pkg::OFF_SECCNT: rdMux[15:0] = secondary_pwm_counter;
            tppc_pkg::OFF_PERIOD: rdMux[15:0] = pwm_period_register;
            tppc_pkg::OFF_TR0:          rdMux[15:0] = trans_r[0];
            tppc_pkg::OFF_TR0 + 8'h04:  rdMux[15:0] = trans_r[1];
            tppc_pkg::OFF_TR0 + 8'h08:  rdMux[15:0] = trans_r[2];
            tppc_pkg::OFF_BUF0:         rdMux[15:0] = buf_r[0];
            tppc_pkg::OFF_BUF0 + 8'h04: rdMux[15:0] = buf_r[1];
            tppc_pkg::OFF_BUF0 + 8'h08: rdMux[15:0] = buf_r[2];
            tppc_pkg::OFF_QCNT:   rdMux[15:0] = quadrature_counter;
            tppc_pkg::OFF_QCMPA:  rdMux[15:0] = quad_compare_a;
            tppc_pkg::OFF_QCMPB:  rdMux[15:0] = quad_compare_b;
            default:              rdHit = 1'b0;
        endcase
    end

    // one wait-free access phase: ready rises the cycle after setup
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel & ~penable;
            prdata_r  <= rdMux;
            pslverr_r <= psel & ~penable & ~rdHit;
        end
    end
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // control register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) ctrl_r <= tppc_pkg::CTRL_RST;
        else if (wrCtrl) ctrl_r <= pwdata[8:0];
    end

    // sticky flags, write 0 clears, a set in the same cycle wins
    wire [4:0] flagSet;
    wire [4:0] flagClr = wrStat ? ~pwdata[4:0] : 5'h00;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) stat_r <= 5'h00;
        else stat_r <= flagSet | (stat_r & ~flagClr);
    end

    // period register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) pwm_period_register <= tppc_pkg::CNT_MAX;
        else if (wrPer) pwm_period_register <= pwdata[15:0];
    end

    // primary counter; a software load overrides counting
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) primary_pwm_counter <= tppc_pkg::CNT_ZERO;
        else if (wrPri) primary_pwm_counter <= pwdata[15:0];
        else if (rsync) primary_pwm_counter <= perHit ? tppc_pkg::CNT_ZERO
                                               : primary_pwm_counter + tppc_pkg::CNT_ONE;
        else if (comp) primary_pwm_counter <= up ? primary_pwm_counter + tppc_pkg::CNT_ONE
                                              : primary_pwm_counter - tppc_pkg::CNT_ONE;
    end

    // secondary counter: free in reset-sync, wraps on undershoot in comp
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) secondary_pwm_counter <= tppc_pkg::CNT_ZERO;
        else if (wrSec) secondary_pwm_counter <= pwdata[15:0];
        else if (rsync | (comp & up)) secondary_pwm_counter <= secondary_pwm_counter
                                                              + tppc_pkg::CNT_ONE;
        else if (comp) secondary_pwm_counter <= secondary_pwm_counter
                                                - tppc_pkg::CNT_ONE;
    end

    // count direction, both counters share it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) dir_r <= tppc_pkg::TPPC_UP;
        else if (!comp) dir_r <= tppc_pkg::TPPC_UP;
        else if (turnDown) dir_r <= tppc_pkg::TPPC_DOWN;
        else if (underflow) dir_r <= tppc_pkg::TPPC_UP;
    end

    // per-phase transition, buffer and output logic
    logic lvlPos_r [3];
    logic lvlNeg_r [3];
    logic pinPos_r [3];
    logic pinNeg_r [3];
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gPhase
            wire [7:0] trOff  = tppc_pkg::OFF_TR0 + 8'(4 * g);
            wire [7:0] bufOff = tppc_pkg::OFF_BUF0 + 8'(4 * g);
            wire priHit = (primary_pwm_counter == trans_r[g]);
            wire secHit = (secondary_pwm_counter == trans_r[g]);
            wire ols = ctrl_r[(g == 0) ? tppc_pkg::CTRL_OLSL : tppc_pkg::CTRL_OLSH];
            // a value above period never matches in reset-sync, so output holds
            wire posNxt = rsync ? (perHit | (lvlPos_r[g] & ~priHit))
                        : comp ? ((~up & priHit) | (lvlPos_r[g] & ~(up & priHit)))
                        : 1'b0;
            wire negRaw = rsync ? (~perHit & (priHit | lvlNeg_r[g]))
                        : comp ? ((up & secHit) | (lvlNeg_r[g] & ~(~up & secHit)))
                        : 1'b0;
            // gating keeps the pair exclusive even with bad preloads
            wire negNxt = negRaw & ~posNxt;

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) trans_r[g] <= tppc_pkg::CNT_MAX;
                else if (wrEn && hitReg(paddr, trOff)) trans_r[g] <= pwdata[15:0];
                else if (bufXfer) trans_r[g] <= buf_r[g];
            end

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) buf_r[g] <= tppc_pkg::CNT_MAX;
                else if (wrEn && hitReg(paddr, bufOff)) buf_r[g] <= pwdata[15:0];
            end

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    lvlPos_r[g] <= 1'b0;
                    lvlNeg_r[g] <= 1'b0;
                    pinPos_r[g] <= 1'b0;
                    pinNeg_r[g] <= 1'b0;
                end else begin
                    lvlPos_r[g] <= posNxt;
                    lvlNeg_r[g] <= negNxt;
                    pinPos_r[g] <= (rsync | comp) & (lvlPos_r[g] ~^ ols);
                    pinNeg_r[g] <= (rsync | comp) & (lvlNeg_r[g] ~^ ols);
                end
            end
        end
    endgenerate

    // pin takeover in either pwm mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) pwmPinEn <= 1'b0;
        else pwmPinEn <= rsync | comp;
    end
    assign phase1_out   = pinPos_r[0];
    assign phase1_out_n = pinNeg_r[0];
    assign phase2_out   = pinPos_r[1];
    assign phase2_out_n = pinNeg_r[1];
    assign phase3_out   = pinPos_r[2];
    assign phase3_out_n = pinNeg_r[2];

    // encoder inputs: three stages, change accepted when last two agree
    logic [2:0] qaSync_r;
    logic [2:0] qbSync_r;
    logic       qaF_r;
    logic       qbF_r;
    logic       qaP_r;
    logic       qbP_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            qaSync_r <= 3'h0;
            qbSync_r <= 3'h0;
            qaF_r    <= 1'b0;
            qbF_r    <= 1'b0;
            qaP_r    <= 1'b0;
            qbP_r    <= 1'b0;
        end else begin
            qaSync_r <= {qaSync_r[1:0], quad_input_a};
            qbSync_r <= {qbSync_r[1:0], quad_input_b};
            if (qaSync_r[1] == qaSync_r[2]) qaF_r <= qaSync_r[2];
            if (qbSync_r[1] == qbSync_r[2]) qbF_r <= qbSync_r[2];
            qaP_r <= qaF_r;
            qbP_r <= qbF_r;
        end
    end

    // both edges of both inputs; simultaneous edges are dropped
    wire qen   = ctrl_r[tppc_pkg::CTRL_QEN];
    wire aEdge = qaF_r ^ qaP_r;
    wire bEdge = qbF_r ^ qbP_r;
    wire qStep = qen & (aEdge ^ bEdge);
    wire qUp   = aEdge ? (qaF_r ^ qbF_r) : (qaF_r ~^ qbF_r);
    wire qHitA = (quadrature_counter == quad_compare_a);
    wire qHitB = (quadrature_counter == quad_compare_b);
    wire [1:0] qClr = ctrl_r[tppc_pkg::CTRL_QCLR +: 2];
    wire qClear = (qHitA & (qClr == tppc_pkg::QCLR_A)) | (qHitB & (qClr == tppc_pkg::QCLR_B));
    wire qWrap = qUp ? (quadrature_counter == tppc_pkg::CNT_MAX)
                     : (quadrature_counter == tppc_pkg::CNT_ZERO);

    // quadrature counter; no prescale or edge select applies here
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) quadrature_counter <= tppc_pkg::CNT_ZERO;
        else if (wrQcnt) quadrature_counter <= pwdata[15:0];
        else if (qStep) quadrature_counter <= qClear ? tppc_pkg::CNT_ZERO
                       : qUp ? quadrature_counter + tppc_pkg::CNT_ONE
                       : quadrature_counter - tppc_pkg::CNT_ONE;
    end

    // quadrature compare values
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            quad_compare_a <= tppc_pkg::CNT_MAX;
            quad_compare_b <= tppc_pkg::CNT_MAX;
        end else begin
            if (wrQa) quad_compare_a <= pwdata[15:0];
            if (wrQb) quad_compare_b <= pwdata[15:0];
        end
    end

    assign flagSet = {qStep & qWrap & ~qClear, qStep & qHitB, qStep & qHitA,
                      ovfSet, cmpaSet};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_rsync_clear;
        rsync & perHit & ~wrPri |=> primary_pwm_counter == tppc_pkg::CNT_ZERO;
    endproperty
    a_rsync_clear: assert property (p_rsync_clear) else $error("no clear at period");

    property p_sec_free;
        rsync & ~wrSec |=> secondary_pwm_counter == $past(secondary_pwm_counter) + 16'h0001;
    endproperty
    a_sec_free: assert property (p_sec_free) else $error("secondary not free");

    property p_rsync_out;
        rsync & perHit |=> lvlPos_r[0] & ~lvlNeg_r[0];
    endproperty
    a_rsync_out: assert property (p_rsync_out) else $error("pair not set at clear");

    property p_turn_down;
        turnDown & ~wrPri ##1 comp
            |-> ~up && primary_pwm_counter == pwm_period_register + 16'h0001;
    endproperty
    a_turn_down: assert property (p_turn_down) else $error("no overshoot turn");

    property p_undershoot;
        underflow & ~wrSec |=> secondary_pwm_counter == tppc_pkg::CNT_MAX ##1 up;
    endproperty
    a_undershoot: assert property (p_undershoot) else $error("no undershoot");

    property p_ovf_flag;
        comp & ~underflow & ~stat_r[tppc_pkg::ST_OVF] |=> ~stat_r[tppc_pkg::ST_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag misset");

    property p_buf_xfer;
        bufXfer & ~(wrEn & hitReg(paddr, tppc_pkg::OFF_TR0)) |=> trans_r[0] == $past(buf_r[0]);
    endproperty
    a_buf_xfer: assert property (p_buf_xfer) else $error("buffer not copied");

    property p_exclusive;
        // ungated terms, so the match ordering itself is what keeps pairs apart
        ~(gPhase[0].posNxt & gPhase[0].negRaw) and ~(gPhase[1].posNxt & gPhase[1].negRaw)
        and ~(gPhase[2].posNxt & gPhase[2].negRaw);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("pair overlap");

    property p_quad_up;
        qStep & qUp & ~qClear & ~wrQcnt
            |=> quadrature_counter == $past(quadrature_counter) + 16'h0001;
    endproperty
    a_quad_up: assert property (p_quad_up) else $error("quad count wrong");

    c_turn: cover property (turnDown ##[1:300] underflow);
    c_bufx: cover property (comp & bufXfer);
    c_quad: cover property (qStep & ~qUp);
endmodule

// ===== rtl/tppc_pkg.sv
/*
 * Constants for the three-phase PWM and phase counter block:
 * register offsets, control and status field positions, mode codes.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package tppc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STAT   = 8'h04;
    localparam logic [7:0] OFF_PRICNT = 8'h08;
    localparam logic [7:0] OFF_SECCNT = 8'h0C;
    localparam logic [7:0] OFF_PERIOD = 8'h10;
    localparam logic [7:0] OFF_TR0    = 8'h14;
    localparam logic [7:0] OFF_BUF0   = 8'h20;
    localparam logic [7:0] OFF_QCNT   = 8'h2C;
    localparam logic [7:0] OFF_QCMPA  = 8'h30;
    localparam logic [7:0] OFF_QCMPB  = 8'h34;
    // control fields
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_BUF  = 3;
    localparam int CTRL_OLSL = 4;
    localparam int CTRL_OLSH = 5;
    localparam int CTRL_QEN  = 6;
    localparam int CTRL_QCLR = 7;
    localparam int CTRL_W    = 9;
    localparam logic [8:0] CTRL_RST = 9'h030;
    // status fields
    localparam int ST_CMPA = 0;
    localparam int ST_OVF  = 1;
    localparam int ST_QA   = 2;
    localparam int ST_QB   = 3;
    localparam int ST_QOVF = 4;
    localparam int ST_DIR  = 5;
    localparam int ST_W    = 5;
    // modes and clear selects
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_RSYNC = 2'h1;
    localparam logic [1:0] MODE_COMP  = 2'h2;
    localparam logic [1:0] QCLR_A     = 2'h1;
    localparam logic [1:0] QCLR_B     = 2'h2;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    typedef enum logic {TPPC_UP, TPPC_DOWN} tppc_dir_t;
endpackage

// ===== testbench/tppc_partner.sv
/*
 * Far-side model: gate-driver monitor on the six pwm pins and a
 * quadrature encoder that steps its two phases when the bench asks.
 * Assumes the bench calls step() from one process only.
 */
module tppc_partner (
    // clock
    input  wire logic ref_clk,
    // pwm pins from the block, overlap check enable from the bench
    input  wire logic phase1_out,
    input  wire logic phase1_out_n,
    input  wire logic phase2_out,
    input  wire logic phase2_out_n,
    input  wire logic phase3_out,
    input  wire logic phase3_out_n,
    input  wire logic overlapChk,
    // encoder lines
    output logic      quad_input_a,
    output logic      quad_input_b,
    // gate driver shoot-through count
    output int        shootCnt
);
    timeunit 1ns;
    timeprecision 100ps;

    int encIdx;

    // encoder starts at rest, both lines low
    initial begin
        quad_input_a = 1'b0;
        quad_input_b = 1'b0;
        shootCnt = 0;
        encIdx = 0;
    end

    // one line changes per step, gray order 00,10,11,01
    task automatic step(input bit up);
        @(posedge ref_clk);
        encIdx = (encIdx + (up ? 1 : 3)) % 4;
        quad_input_a <= (encIdx == 1) || (encIdx == 2);
        quad_input_b <= (encIdx >= 2);
        // wide spacing, the block needs two stable clocks
        repeat (8) @(posedge ref_clk);
    endtask

    // a pair driven high together would short the half bridge
    always @(posedge ref_clk) begin
        if (overlapChk && ((phase1_out && phase1_out_n) || (phase2_out && phase2_out_n)
            || (phase3_out && phase3_out_n))) begin
            shootCnt <= shootCnt + 1;
        end
    end
endmodule

// ===== testbench/tb_top.sv
/*
 * Self-checking bench for tppc_top: apb master, integer model of pwm
 * duty counts and quadrature count, far-side partner on the pins.
 * Assumes registers at the package offsets and an apb slave with pready.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        phase1_out, phase1_out_n, phase2_out, phase2_out_n;
    logic        phase3_out, phase3_out_n, pwmPinEn;
    logic        quad_input_a, quad_input_b;
    logic        overlapChk = 1'b0;
    int          shootCnt;
    int          num_errors = 0;
    int          n_tests = 0;
    int          pc[6];
    logic [31:0] rd;
    logic        err;
    wire  [5:0]  pinVec = {phase3_out_n, phase3_out, phase2_out_n, phase2_out,
                           phase1_out_n, phase1_out};

    always #2 ref_clk = ~ref_clk;

    tppc_top u_tppc_top (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase1_out(phase1_out), .phase1_out_n(phase1_out_n),
        .phase2_out(phase2_out), .phase2_out_n(phase2_out_n), .phase3_out(phase3_out),
        .phase3_out_n(phase3_out_n), .pwmPinEn(pwmPinEn), .quad_input_a(quad_input_a),
        .quad_input_b(quad_input_b));

    tppc_partner u_tppc_partner (.ref_clk(ref_clk), .phase1_out(phase1_out),
        .phase1_out_n(phase1_out_n), .phase2_out(phase2_out), .phase2_out_n(phase2_out_n),
        .phase3_out(phase3_out), .phase3_out_n(phase3_out_n), .overlapChk(overlapChk),
        .quad_input_a(quad_input_a), .quad_input_b(quad_input_b), .shootCnt(shootCnt));

    // verdict, reached from the main sequence or a timeout
    task automatic wrap_up();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input int d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // high cycles of every pin over n clocks
    task automatic meas(input int n);
        pc = '{default: 0};
        repeat (n) begin
            @(posedge ref_clk);
            for (int j = 0; j < 6; j++) begin
                pc[j] += (pinVec[j] === 1'b1) ? 1 : 0;
            end
        end
    endtask

    // hang guard, far above the expected run length
    initial begin
        #40000;
        num_errors++;
        wrap_up();
    end

    initial begin
        int p, t, g, m, y, len, n, qExp;
        bit d;
        bit dirQ[$];
        void'($urandom(32'h360FA944));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset state, pins idle while no pwm mode runs
        rdc(tppc_pkg::OFF_CTRL, 32'h00000030);
        rdc(tppc_pkg::OFF_STAT, 32'h00000000);
        chk({pwmPinEn, pinVec}, 7'h00);
        apb(1'b0, 8'hFC, 32'h00000000);
        chk(err, 1'b1);
        chk(rd, 32'h00000000);
        // reset-sync, second pass inverts phase1 only
        p = 19;
        for (int i = 0; i < 2; i++) begin
            t = 2 + $urandom_range(15);
            wr(tppc_pkg::OFF_CTRL, 0);
            wr(tppc_pkg::OFF_PRICNT, 0);
            wr(tppc_pkg::OFF_PERIOD, p);
            wr(tppc_pkg::OFF_TR0, t);
            wr(tppc_pkg::OFF_CTRL, (i ? 32'h20 : 32'h30) | (tppc_pkg::MODE_RSYNC << 1) | 1);
            repeat (2 * p) @(posedge ref_clk);
            meas(3 * (p + 1));
            chk(pc[0], i ? 3 * (p - t) : 3 * (t + 1));
            chk(pc[1], i ? 3 * (t + 1) : 3 * (p - t));
            chk(pc[2], 3 * (p + 1));
            chk(pc[4], 3 * (p + 1));
            chk(pc[3] + pc[5], 0);
            chk(pwmPinEn, 1'b1);
            apb(1'b0, tppc_pkg::OFF_SECCNT, 32'h00000000);
            n = rd;
            apb(1'b0, tppc_pkg::OFF_SECCNT, 32'h00000000);
            chk(32'(16'(rd - n)), 32'h00000003);
        end
        // complementary with buffered update of phases 1 and 3
        g = 20;
        m = 3;
        y = 5 + $urandom_range(10);
        len = 2 * (g - m + 2);
        wr(tppc_pkg::OFF_CTRL, 32'h30);
        wr(tppc_pkg::OFF_PRICNT, m);
        wr(tppc_pkg::OFF_SECCNT, 0);
        wr(tppc_pkg::OFF_PERIOD, g);
        // flags left by reset-sync would hide the complementary ones
        wr(tppc_pkg::OFF_STAT, 0);
        for (int i = 0; i < 3; i++) begin
            wr(tppc_pkg::OFF_TR0 + 8'(4 * i), 5 + $urandom_range(10));
            wr(tppc_pkg::OFF_BUF0 + 8'(4 * i), (i == 1) ? 32'h40 : y);
        end
        wr(tppc_pkg::OFF_CTRL, 32'h39 | (tppc_pkg::MODE_COMP << 1));
        overlapChk <= 1'b1;
        repeat (3 * len) @(posedge ref_clk);
        rdc(tppc_pkg::OFF_TR0, y);
        meas(3 * len);
        chk(3 * len - pc[0], 6 * (g - y + 1));
        chk(pc[1], 6 * (g - m - y + 1));
        chk(3 * len - pc[4], 6 * (g - y + 1));
        chk(pc[5], 6 * (g - m - y + 1));
        chk(pc[2] == 0 || pc[2] == 3 * len, 1'b1);
        chk(pc[3], 3 * len - pc[2]);
        apb(1'b0, tppc_pkg::OFF_STAT, 32'h00000000);
        chk(rd[1:0], 2'b11);
        overlapChk <= 1'b0;
        chk(shootCnt, 0);
        // quadrature, random walk after a climb past compare A
        wr(tppc_pkg::OFF_CTRL, 32'h30 | (1 << tppc_pkg::CTRL_QEN));
        wr(tppc_pkg::OFF_QCNT, 0);
        wr(tppc_pkg::OFF_QCMPA, 2);
        wr(tppc_pkg::OFF_STAT, 0);
        qExp = 0;
        repeat (3) dirQ.push_back(1'b1);
        repeat (12) dirQ.push_back(1'($urandom_range(1)));
        while (dirQ.size() > 0) begin
            d = dirQ.pop_front();
            u_tppc_partner.step(d);
            qExp += d ? 1 : -1;
        end
        rdc(tppc_pkg::OFF_QCNT, 32'(16'(qExp)));
        apb(1'b0, tppc_pkg::OFF_STAT, 32'h00000000);
        chk(rd[tppc_pkg::ST_QA], 1'b1);
        // clear on compare A: step six clears to zero
        wr(tppc_pkg::OFF_QCNT, 0);
        wr(tppc_pkg::OFF_QCMPA, 5);
        wr(tppc_pkg::OFF_CTRL, 32'h70 | (tppc_pkg::QCLR_A << tppc_pkg::CTRL_QCLR));
        repeat (8) u_tppc_partner.step(1'b1);
        rdc(tppc_pkg::OFF_QCNT, 32'h00000002);
        wrap_up();
    end
endmodule
